/* File: fsp_regs.svh */
// Register offsets, field positions, reset values, flash command codes and timing counts
// for the parallel NOR flash host controller. Included by the design modules and the bench.
//
// Notes on behaviour
// - Ready line valid only after final write strobe.
// - Status polls use address inside target block.
// - Wait recovery time after reset before reads.
// - Every program needs three-write unlock prefix.
// - Every erase needs full six-write sequence.
// - Query entry single write; exit command needed.
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// Register byte offsets
`define FSP_OFF_CMD 8'h00
`define FSP_OFF_CFG 8'h04
`define FSP_OFF_ADDR 8'h08
`define FSP_OFF_WDATA 8'h0C
`define FSP_OFF_RDATA 8'h10
`define FSP_OFF_STATUS 8'h14

// Command register opcodes (bits 3:0)
`define FSP_OP_READ 4'h0
`define FSP_OP_PROG 4'h1
`define FSP_OP_BERASE 4'h2
`define FSP_OP_CERASE 4'h3
`define FSP_OP_QENTRY 4'h4
`define FSP_OP_QEXIT 4'h5
`define FSP_OP_IDENTRY 4'h6
`define FSP_OP_IDEXIT 4'h7
`define FSP_OP_ABORTRST 4'h8
`define FSP_OP_HWRESET 4'h9

// Config register bits and reset value
`define FSP_CFG_WP_BIT 0
`define FSP_CFG_TOP_BIT 1
`define FSP_CFG_UNIF_BIT 2
`define FSP_CFG_RESET 3'h7

// Status register bits
`define FSP_ST_BUSY_BIT 0
`define FSP_ST_READY_BIT 1
`define FSP_ST_DONE_BIT 2
`define FSP_ST_REJ_BIT 3
`define FSP_ST_RBVALID_BIT 4

// Flash command addresses and data
`define FSP_UNLOCK_A1 22'h00_0555
`define FSP_UNLOCK_A2 22'h00_02AA
`define FSP_QUERY_A 22'h00_0055
`define FSP_UNLOCK_D1 16'h00AA
`define FSP_UNLOCK_D2 16'h0055
`define FSP_CMD_PROG 16'h00A0
`define FSP_CMD_ERASE 16'h0080
`define FSP_CMD_BERASE 16'h0050
`define FSP_CMD_CERASE 16'h0010
`define FSP_CMD_QUERY 16'h0098
`define FSP_CMD_ID 16'h0090
`define FSP_CMD_EXIT 16'h00F0

// Boot block ranges
`define FSP_BOOT_TOP_U_LO 22'h3F_8000
`define FSP_BOOT_BOT_U_HI 22'h00_7FFF
`define FSP_BOOT_TOP_N_LO 22'h3F_E000
`define FSP_BOOT_BOT_N_HI 22'h00_1FFF

// Timing: times in ns, counts in cycles of the clock
`define FSP_CLK_NS 100
`define FSP_GLITCH_NS 5
`define FSP_RC_NS 70
`define FSP_RP_NS 500
`define FSP_RHR_NS 1000
`define FSP_WE_CYC ((`FSP_GLITCH_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_RC_CYC ((`FSP_RC_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_RP_CYC ((`FSP_RP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_RHR_CYC ((`FSP_RHR_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

// AXI responses
`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2

`endif

/* File: fsp_pkg.sv */
// Types shared by the flash host controller modules.
// Assumes fsp_regs.svh is on the include path.
package fsp_pkg;
  typedef logic [21:0] fsp_addr_t;
  typedef logic [15:0] fsp_word_t;
  // Bus cycle engine states
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fsp_cyc_e;
  // Command sequencer states
  typedef enum logic [2:0] {SQ_IDLE, SQ_WAITRDY, SQ_ISSUE, SQ_WAIT, SQ_POLL, SQ_PWAIT, SQ_RSTLOW,
                            SQ_RSTREC} fsp_seq_e;
endpackage

/* File: fsp_cyc_if.sv */
// Request and answer between the command sequencer and the flash bus cycle engine.
// Assumes fsp_pkg is compiled first.
`timescale 1ns/1ns
interface fsp_cyc_if;
  logic start;                 // One-cycle request, taken only while idle
  logic isWrite;               // Write cycle when high, read otherwise
  fsp_pkg::fsp_addr_t addr;    // Word address of the cycle
  fsp_pkg::fsp_word_t wdata;   // Write data
  fsp_pkg::fsp_word_t rdata;   // Captured read data
  logic done;                  // One-cycle pulse at the end of the cycle
  logic idle;                  // Engine free
  modport seq (output start, isWrite, addr, wdata, input rdata, done, idle);
  modport cyc (input start, isWrite, addr, wdata, output rdata, done, idle);
endinterface

/* File: fsp_cycle.sv */
// Single read or write cycle on the asynchronous flash pins.
// Assumes requests arrive one at a time through fsp_cyc_if and data inputs are synchronous.
`timescale 1ns/1ns
`include "fsp_regs.svh"
module fsp_cycle (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Request from sequencer
  fsp_cyc_if.cyc bus,
  // Flash pins
  output logic flashCs_b,
  output logic flashWe_b,
  output logic flashOe_b,
  output fsp_pkg::fsp_addr_t flashAddr,
  output fsp_pkg::fsp_word_t flashDqOut,
  output logic flashDqOe,
  input wire fsp_pkg::fsp_word_t flashDqIn
);
  import fsp_pkg::*;

  fsp_cyc_e state;       // Cycle phase
  logic writing;         // Latched direction
  logic [3:0] cnt;       // Strobe length counter
  fsp_word_t rdata;      // Captured read word
  logic done;            // End pulse

  // Strobe length: write pulse well above the glitch floor, read meets the read cycle time
  wire [3:0] strobeLen = writing ? 4'(`FSP_WE_CYC - 1) : 4'(`FSP_RC_CYC - 1);
  wire strobeEnd = (state == CY_STROBE) && (cnt == 4'h0);

  assign bus.idle = (state == CY_IDLE);
  assign bus.rdata = rdata;
  assign bus.done = done;

  // Phase machine; address and data settle one cycle before the strobe falls
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= CY_IDLE;
      writing <= 1'b0;
      cnt <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        CY_IDLE: begin
          if (bus.start) begin
            writing <= bus.isWrite;
            state <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          cnt <= strobeLen;
          state <= CY_STROBE;
        end
        CY_STROBE: begin
          // Strobe held whole cycles so no sub-5 ns pulse can reach the pin
          if (strobeEnd) begin
            state <= CY_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          done <= 1'b1;
          state <= CY_IDLE;
        end
      endcase
    end
  end

  // Pin drivers; write enable and output enable never low together
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flashCs_b <= 1'b1;
      flashWe_b <= 1'b1;
      flashOe_b <= 1'b1;
      flashDqOe <= 1'b0;
    end else begin
      // Select stays low through the strobe's rising edge, so the write lands while the part is selected
      flashCs_b <= !((state == CY_IDLE && bus.start) || state == CY_SETUP || state == CY_STROBE);
      flashWe_b <= !(writing && (state == CY_SETUP || (state == CY_STROBE && !strobeEnd)));
      flashOe_b <= !(!writing && (state == CY_SETUP || (state == CY_STROBE && !strobeEnd)));
      // Data held one cycle past the rising write strobe
      flashDqOe <= (state == CY_IDLE) ? (bus.start && bus.isWrite) : (writing && state != CY_HOLD);
    end
  end

  // Address, write data and captured read data
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flashAddr <= 22'h00_0000;
      flashDqOut <= 16'h0000;
      rdata <= 16'h0000;
    end else begin
      if (state == CY_IDLE && bus.start) begin
        flashAddr <= bus.addr;
        flashDqOut <= bus.wdata;
      end
      if (strobeEnd && !writing) begin
        rdata <= flashDqIn;
      end
    end
  end

  property p_write_inhibit;
    @(posedge clock) disable iff (!rst_b) !flashWe_b |-> flashOe_b && !flashCs_b && flashDqOe;
  endproperty
  a_write_inhibit: assert property (p_write_inhibit) else $error("write strobe low while inhibited");

  property p_strobe_len;
    @(posedge clock) disable iff (!rst_b) $fell(flashWe_b) |-> !flashWe_b[*1] ##1 flashWe_b ##1 flashCs_b;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("write strobe length wrong");
endmodule

/* File: fsp_host.sv */
// Host controller for a 16-bit asynchronous NOR flash, commanded over AXI4-Lite.
// Assumes one clock, synchronous flash inputs and an external pull-up on the ready line.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "fsp_regs.svh"
module fsp_host #(
  parameter int AXI_ADDR_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AXI4-Lite write channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash pins
  output logic flashCs_b,
  output logic flashWe_b,
  output logic flashOe_b,
  output fsp_pkg::fsp_addr_t flashAddr,
  output fsp_pkg::fsp_word_t flashDqOut,
  output logic flashDqOe,
  input wire fsp_pkg::fsp_word_t flashDqIn,
  output logic flashRst_b,
  output logic flashWp_b,
  input wire logic flashReadyBusy_b
);
  import fsp_pkg::*;

  fsp_cyc_if cycIf ();

  // Software registers
  logic [2:0] cfg;          // Write protect level, top boot, uniform boot
  fsp_addr_t opAddr;        // Target word address
  fsp_word_t opData;        // Program data
  fsp_word_t rdData;        // Last word read from the flash
  logic doneFlag;           // Sticky: last command finished
  logic rejFlag;            // Sticky: last command refused by boot protection
  logic rbValid;            // Ready line meaningful since final strobe

  // AXI slave state
  logic awHeld, wHeld;
  logic [AXI_ADDR_W-1:0] awAddr;
  logic [31:0] wData;

  // Sequencer state
  fsp_seq_e seq;
  logic [3:0] opReg;
  logic [2:0] step;
  logic [2:0] wrCount;      // Writes issued in this command
  logic [7:0] cnt;          // Reset timing counter
  logic prevToggle;
  logic havePrev;

  // AXI handshakes and write decode
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wrFire = awHeld && wHeld && !s_axi_bvalid;
  wire [7:0] wrOff = 8'(awAddr);
  wire [7:0] rdOff = 8'(s_axi_araddr);
  wire seqIdle = (seq == SQ_IDLE);
  wire wrCmd = wrFire && (wrOff == `FSP_OFF_CMD);
  wire cmdWr = wrCmd && seqIdle && s_axi_wstrb[0];
  wire wrKnown = (wrOff == `FSP_OFF_CMD) || (wrOff == `FSP_OFF_CFG) || (wrOff == `FSP_OFF_ADDR) ||
                 (wrOff == `FSP_OFF_WDATA) || (wrOff == `FSP_OFF_RDATA) || (wrOff == `FSP_OFF_STATUS);
  // A command while the sequencer is busy is refused with an error
  wire [1:0] wrResp = (!wrKnown || (wrCmd && !seqIdle)) ? `FSP_RESP_SLVERR : `FSP_RESP_OKAY;
  wire [3:0] newOp = wData[3:0];

  // Boot block decode for the configured variant
  wire inBootU = cfg[`FSP_CFG_TOP_BIT] ? (opAddr >= `FSP_BOOT_TOP_U_LO) : (opAddr <= `FSP_BOOT_BOT_U_HI);
  wire inBootN = cfg[`FSP_CFG_TOP_BIT] ? (opAddr >= `FSP_BOOT_TOP_N_LO) : (opAddr <= `FSP_BOOT_BOT_N_HI);
  wire inBoot = cfg[`FSP_CFG_UNIF_BIT] ? inBootU : inBootN;
  // Refuse locally what the flash would silently ignore, so software learns of it
  wire protHit = !cfg[`FSP_CFG_WP_BIT] &&
                 (newOp == `FSP_OP_CERASE || ((newOp == `FSP_OP_PROG || newOp == `FSP_OP_BERASE) && inBoot));

  // Register read mux
  wire [31:0] statusWord = {27'h000_0000, rbValid, rejFlag, doneFlag, flashReadyBusy_b, !seqIdle};
  wire rdKnown = (rdOff == `FSP_OFF_CMD) || (rdOff == `FSP_OFF_CFG) || (rdOff == `FSP_OFF_ADDR) ||
                 (rdOff == `FSP_OFF_WDATA) || (rdOff == `FSP_OFF_RDATA) || (rdOff == `FSP_OFF_STATUS);
  wire [31:0] rdMux = (rdOff == `FSP_OFF_CMD) ? {28'h000_0000, opReg} :
                      (rdOff == `FSP_OFF_CFG) ? {29'h0000_0000, cfg} :
                      (rdOff == `FSP_OFF_ADDR) ? {10'h000, opAddr} :
                      (rdOff == `FSP_OFF_WDATA) ? {16'h0000, opData} :
                      (rdOff == `FSP_OFF_RDATA) ? {16'h0000, rdData} :
                      (rdOff == `FSP_OFF_STATUS) ? statusWord : 32'h0000_0000;

  // Command sequence table: unlock prefix, then command, then target
  function automatic logic [37:0] seqWord(input logic [3:0] op, input logic [2:0] st,
                                          input fsp_addr_t a, input fsp_word_t d);
    logic [37:0] w;
    w = {a, d};
    if (op == `FSP_OP_QENTRY) begin
      w = {`FSP_QUERY_A, `FSP_CMD_QUERY};
    end else if (op == `FSP_OP_QEXIT || op == `FSP_OP_IDEXIT) begin
      w = {22'h00_0000, `FSP_CMD_EXIT};
    end else if (op == `FSP_OP_READ) begin
      w = {a, d};
    end else if (st == 3'h0 || st == 3'h3) begin
      w = (op == `FSP_OP_PROG && st == 3'h3) ? {a, d} : {`FSP_UNLOCK_A1, `FSP_UNLOCK_D1};
    end else if (st == 3'h1 || st == 3'h4) begin
      w = {`FSP_UNLOCK_A2, `FSP_UNLOCK_D2};
    end else if (st == 3'h2) begin
      w = {`FSP_UNLOCK_A1, (op == `FSP_OP_PROG) ? `FSP_CMD_PROG : (op == `FSP_OP_IDENTRY) ? `FSP_CMD_ID :
           (op == `FSP_OP_ABORTRST) ? `FSP_CMD_EXIT : `FSP_CMD_ERASE};
    end else begin
      w = (op == `FSP_OP_BERASE) ? {a, `FSP_CMD_BERASE} : {`FSP_UNLOCK_A1, `FSP_CMD_CERASE};
    end
    return w;
  endfunction

  // Index of the final write of each command
  wire [2:0] lastStep = (opReg == `FSP_OP_PROG) ? 3'h3 :
                        (opReg == `FSP_OP_BERASE || opReg == `FSP_OP_CERASE) ? 3'h5 :
                        (opReg == `FSP_OP_IDENTRY || opReg == `FSP_OP_ABORTRST) ? 3'h2 : 3'h0;
  wire [37:0] curWord = seqWord(opReg, step, opAddr, opData);
  wire isPolled = (opReg == `FSP_OP_PROG) || (opReg == `FSP_OP_BERASE) || (opReg == `FSP_OP_CERASE);
  wire polling = (seq == SQ_POLL);
  // Polls read the target address so the status bits belong to the block in work
  assign cycIf.start = ((seq == SQ_ISSUE) || polling) && cycIf.idle;
  assign cycIf.isWrite = !polling && (opReg != `FSP_OP_READ);
  assign cycIf.addr = polling ? opAddr : curWord[37:16];
  assign cycIf.wdata = curWord[15:0];
  wire toggleStill = havePrev && (cycIf.rdata[6] == prevToggle);
  wire rstDone = (cnt == 8'h00);
  assign flashRst_b = (seq != SQ_RSTLOW);
  assign flashWp_b = cfg[`FSP_CFG_WP_BIT];

  fsp_cycle uCycle (
    .clock(clock),
    .rst_b(rst_b),
    .bus(cycIf.cyc),
    .flashCs_b(flashCs_b),
    .flashWe_b(flashWe_b),
    .flashOe_b(flashOe_b),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn)
  );

  // AXI channel holding and responses
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FSP_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `FSP_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrResp;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdKnown ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software-written registers; cfg needs byte enable 0, the address and data registers ignore the byte enables
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= `FSP_CFG_RESET;
      opAddr <= 22'h00_0000;
      opData <= 16'h0000;
    end else if (wrFire) begin
      if (wrOff == `FSP_OFF_CFG && s_axi_wstrb[0]) cfg <= wData[2:0];
      if (wrOff == `FSP_OFF_ADDR && seqIdle) opAddr <= wData[21:0];
      if (wrOff == `FSP_OFF_WDATA && seqIdle) opData <= wData[15:0];
    end
  end

  // Command sequencer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seq <= SQ_IDLE;
      opReg <= `FSP_OP_READ;
      step <= 3'h0;
      wrCount <= 3'h0;
      cnt <= 8'h00;
      doneFlag <= 1'b0;
      rejFlag <= 1'b0;
      rbValid <= 1'b0;
      rdData <= 16'h0000;
      prevToggle <= 1'b0;
      havePrev <= 1'b0;
    end else begin
      if (cycIf.start && cycIf.isWrite) wrCount <= wrCount + 3'h1;
      case (seq)
        SQ_IDLE: begin
          if (cmdWr) begin
            opReg <= newOp;
            step <= 3'h0;
            wrCount <= 3'h0;
            havePrev <= 1'b0;
            doneFlag <= 1'b0;
            rbValid <= 1'b0;
            rejFlag <= protHit;
            if (protHit) begin
              doneFlag <= 1'b1;
            end else if (newOp == `FSP_OP_HWRESET) begin
              cnt <= 8'(`FSP_RP_CYC - 1);
              seq <= SQ_RSTLOW;
            end else begin
              seq <= SQ_WAITRDY;
            end
          end
        end
        SQ_WAITRDY: begin
          // Exits and new sequences wait for the flash to report ready
          if (flashReadyBusy_b) seq <= SQ_ISSUE;
        end
        SQ_ISSUE: begin
          if (cycIf.start) seq <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (cycIf.done) begin
            if (opReg == `FSP_OP_READ) begin
              rdData <= cycIf.rdata;
              doneFlag <= 1'b1;
              seq <= SQ_IDLE;
            end else if (step == lastStep) begin
              rbValid <= 1'b1;
              seq <= isPolled ? SQ_POLL : SQ_IDLE;
              doneFlag <= !isPolled;
            end else begin
              step <= step + 3'h1;
              seq <= SQ_ISSUE;
            end
          end
        end
        SQ_POLL: begin
          if (cycIf.start) seq <= SQ_PWAIT;
        end
        SQ_PWAIT: begin
          // Two successive reads with the same toggle bit mean the operation ended
          if (cycIf.done) begin
            rdData <= cycIf.rdata;
            prevToggle <= cycIf.rdata[6];
            havePrev <= 1'b1;
            seq <= toggleStill ? SQ_IDLE : SQ_POLL;
            doneFlag <= toggleStill;
          end
        end
        SQ_RSTLOW: begin
          cnt <= rstDone ? 8'(`FSP_RHR_CYC - 1) : cnt - 8'h01;
          if (rstDone) seq <= SQ_RSTREC;
        end
        default: begin
          // No flash access until recovery has elapsed
          cnt <= cnt - 8'h01;
          if (rstDone) begin
            doneFlag <= 1'b1;
            seq <= SQ_IDLE;
          end
        end
      endcase
    end
  end

  property p_rb_valid;
    @(posedge clock) disable iff (!rst_b) $rose(rbValid) |-> $past(seq) == SQ_WAIT && $past(cycIf.done);
  endproperty
  a_rb_valid: assert property (p_rb_valid) else $error("ready line trusted before final strobe");

  property p_prog_prefix;
    @(posedge clock) disable iff (!rst_b)
      (cycIf.start && seq == SQ_ISSUE && opReg == `FSP_OP_PROG && step == 3'h3) |-> wrCount == 3'h3;
  endproperty
  a_prog_prefix: assert property (p_prog_prefix) else $error("program without unlock prefix");

  property p_erase_seq;
    @(posedge clock) disable iff (!rst_b)
      (cycIf.start && seq == SQ_ISSUE && opReg == `FSP_OP_BERASE && step == 3'h5) |-> wrCount == 3'h5;
  endproperty
  a_erase_seq: assert property (p_erase_seq) else $error("erase without six writes");

  property p_poll_addr;
    @(posedge clock) disable iff (!rst_b) (cycIf.start && polling) |-> cycIf.addr == opAddr && !cycIf.isWrite;
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("status poll off target address");

  property p_poll_done;
    @(posedge clock) disable iff (!rst_b)
      ($rose(doneFlag) && $past(seq) == SQ_PWAIT) |-> havePrev && rdData[6] == prevToggle;
  endproperty
  a_poll_done: assert property (p_poll_done) else $error("done while toggle bit still moving");

  property p_rst_pulse;
    @(posedge clock) disable iff (!rst_b) $fell(flashRst_b) |-> !flashRst_b[*5] ##1 flashRst_b;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("flash reset pulse length wrong");

  property p_recovery;
    @(posedge clock) disable iff (!rst_b) $rose(flashRst_b) |-> !cycIf.start[*8];
  endproperty
  a_recovery: assert property (p_recovery) else $error("flash access inside reset recovery");

  property p_boot_refuse;
    @(posedge clock) disable iff (!rst_b) (cmdWr && protHit) |=> seq == SQ_IDLE && rejFlag && doneFlag;
  endproperty
  a_boot_refuse: assert property (p_boot_refuse) else $error("protected command not refused");

  property p_busy_gate;
    @(posedge clock) disable iff (!rst_b) ($past(seq) == SQ_WAITRDY && seq == SQ_ISSUE) |-> $past(flashReadyBusy_b);
  endproperty
  a_busy_gate: assert property (p_busy_gate) else $error("command issued while flash busy");
endmodule

/* File: fsp_flash_model.sv */
// Behavioural flash on the host pins: unlocked program, status polling, reset.
// Assumes the bench puts the pull-up on the ready line and resolves the data bus.
`timescale 1ns/1ns
module fsp_flash_model (
  // Host pins
  input wire logic cs_b,
  input wire logic we_b,
  input wire logic oe_b,
  input wire logic hwRst_b,
  input wire logic [21:0] a,
  input wire logic [15:0] d,
  // Flash side
  output logic [15:0] q,
  output logic pullLow,
  output int writes
);
  logic [15:0] mem = 16'hFFFF; // One stored word, erased
  logic [15:0] last = 16'h0000; // Last program datum
  logic tog = 1'h0; // Toggle bit state
  logic ers = 1'h0; // Busy with an erase rather than a program
  time tw = 0; // Time the write strobe last fell
  int step = 0; // Unlock progress
  int left = 0; // Status reads until the program ends
  initial writes = 0;
  // Open drain: the line is only ever pulled low, and only while busy
  assign pullLow = left != 0;
  // Unselected bus shows a moving pattern, not the last value
  assign q = (cs_b || oe_b) ? ~a[15:0] : (left == 0) ? mem :
    ers ? {8'h00, 1'h0, tog, 3'h1, tog, 2'h0} : {8'h00, ~last[7], tog, 6'h00};
  always @(negedge we_b) tw = $time;
  // A write lands at the strobe rise; a wrong word drops the sequence; a busy part takes no write
  always @(posedge we_b) begin
    if (!cs_b && oe_b && hwRst_b && left == 0 && $time - tw >= 5) begin
      writes++;
      if (step == 3 || (step == 6 && (d == 16'h0050 || d == 16'h0010))) begin
        ers = step == 6;
        last = d;
        left = 4;
      end
      step = (step == 0 && d == 16'h00AA) ? 1 : (step == 1 && d == 16'h0055) ? 2 :
        (step == 2 && d == 16'h00A0) ? 3 : (step == 2 && d == 16'h0080) ? 4 :
        (step == 4 && d == 16'h00AA) ? 5 : (step == 5 && d == 16'h0055) ? 6 : 0;
    end
  end
  // Each finished status read flips the toggle bit
  always @(posedge oe_b) begin
    if (left != 0) begin
      tog = !tog;
      left--;
      if (left == 0) mem = ers ? 16'hFFFF : last;
    end
  end
  // Reset aborts work and forgets the count of writes
  always @(negedge hwRst_b) begin
    left = 0;
    step = 0;
    writes = 0;
  end
endmodule

/* File: tb_top.sv */
// Bench: AXI4-Lite orders to the flash host, flash model on its pins.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ns
`include "fsp_regs.svh"
module tb_top;
  import fsp_pkg::*;
  logic clock = 1'h0, rst_b = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, lastRd;
  logic [3:0] s_axi_wstrb = 4'hF; // Full words only
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pullLow;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic flashCs_b, flashWe_b, flashOe_b, flashDqOe, flashRst_b, flashWp_b, flashReadyBusy_b;
  fsp_addr_t flashAddr;
  fsp_word_t flashDqOut, flashDqIn, mq;
  int writes, w0, i, miscompares = 0, checked = 0;
  // Ops with their write counts, then boot cases: cfg, reject, address
  localparam logic [7:0] OPT [8] = '{8'h41, 8'h51, 8'h63, 8'h71, 8'h26, 8'h36, 8'h83, 8'h00};
  localparam logic [31:0] BT [6] = '{32'h0100_1FFF, 32'h0000_2000, 32'h4100_7FFF, 32'h213F_E000,
    32'h603F_7FFF, 32'h703F_FFFF};
  // Pull-up against the open-drain pull; host drive wins on the data bus
  assign flashReadyBusy_b = !pullLow;
  assign flashDqIn = flashDqOe ? flashDqOut : mq;
  fsp_host i_dut (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flashCs_b, .flashWe_b,
    .flashOe_b, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn, .flashRst_b, .flashWp_b, .flashReadyBusy_b);
  fsp_flash_model i_mem (.cs_b(flashCs_b), .we_b(flashWe_b), .oe_b(flashOe_b), .hwRst_b(flashRst_b),
    .a(flashAddr), .d(flashDqOut), .q(mq), .pullLow, .writes);
  initial begin
    forever #50 clock = !clock;
  end
  // Closing report, also reached when a wait runs out
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [34:0] g, input logic [34:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One AXI access; readies are sampled at the falling edge, acted on at the rise
  task automatic acc(input logic rd, input logic [7:0] ad, input logic [31:0] dt, ex, mk, input logic [1:0] er);
    logic aw, w, ar, b;
    logic [1:0] rs;
    b = 1'h0;
    @(posedge clock);
    if (rd) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
    else {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, dt, 3'h7};
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge clock);
      {aw, w, ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
      {b, rs, lastRd} = rd ? {s_axi_rvalid, s_axi_rresp, s_axi_rdata} : {s_axi_bvalid, s_axi_bresp, 32'h0000_0000};
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (ar) s_axi_arvalid <= 1'h0;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk({b, rs, lastRd & mk}, {1'h1, er, ex & mk});
    if (!b) print_verdict();
  endtask
  // Issue a command, poll until done, compare reject flag and flash writes
  task automatic run(input logic [3:0] op, input logic rej, input int nw);
    w0 = writes;
    acc(0, `FSP_OFF_CMD, 32'(op), 0, 0, `FSP_RESP_OKAY);
    if (op == 4'h1) acc(0, `FSP_OFF_CMD, 32'(op), 0, 0, rej ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR);
    for (int n = 0; n < 40 && !lastRd[2]; n++) acc(1, `FSP_OFF_STATUS, 0, 0, 0, `FSP_RESP_OKAY);
    chk({lastRd[3:2], 32'(writes - w0)}, {rej, 1'h1, 32'(nw)});
    if (!lastRd[2]) print_verdict();
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    acc(1, `FSP_OFF_CFG, 0, 32'h0000_0007, 32'hFFFF_FFFF, `FSP_RESP_OKAY);
    acc(1, 8'h18, 0, 0, 32'hFFFF_FFFF, `FSP_RESP_SLVERR);
    acc(0, `FSP_OFF_ADDR, 32'h0000_0100, 0, 0, `FSP_RESP_OKAY);
    acc(0, `FSP_OFF_WDATA, 32'h0000_00C3, 0, 0, `FSP_RESP_OKAY);
    run(4'h1, 1'h0, 4);
    acc(1, `FSP_OFF_RDATA, 0, 32'h0000_00C3, 32'h0000_FFFF, `FSP_RESP_OKAY);
    // Every other command but the hardware reset, with the writes its sequence needs
    for (i = 0; i < 8; i++) run(OPT[i][7:4], 1'h0, OPT[i][3:0]);
    // Boot range edges for each variant and both protect levels
    for (i = 0; i < 6; i++) begin
      acc(0, `FSP_OFF_CFG, 32'(BT[i][31:28]), 0, 0, `FSP_RESP_OKAY);
      chk(flashWp_b, BT[i][28]);
      acc(0, `FSP_OFF_ADDR, 32'(BT[i][21:0]), 0, 0, `FSP_RESP_OKAY);
      run(4'h1, BT[i][24], BT[i][24] ? 0 : 4);
    end
    run(4'h9, 1'h0, -writes);
    print_verdict();
  end
endmodule
